// ==== inc/io_seq_pkg.sv ====
// Constants for the I/O and interrupt-entry microsequencer
package io_seq_pkg;
   // Datapath and microprogram address widths
   localparam int DATA_W = 16;
   localparam int UPC_W  = 9;
   localparam int COL_W  = 4;

   // Major opcodes of the I/O group (minor field is not decoded)
   localparam logic [3:0] MAJ_INPUT_DIRECT   = 4'h8;
   localparam logic [3:0] MAJ_OUTPUT_DIRECT  = 4'h9;
   localparam logic [3:0] MAJ_INPUT_INDEXED  = 4'ha;
   localparam logic [3:0] MAJ_OUTPUT_INDEXED = 4'hb;

   // Fixed entry points
   localparam logic [UPC_W-1:0] UA_INIT      = 9'h000;
   localparam logic [UPC_W-1:0] UA_FETCH     = 9'h00f;
   localparam logic [UPC_W-1:0] UA_INTERRUPT = 9'h0ff;

   // Placed microinstructions of the I/O and interrupt sequences
   localparam logic [UPC_W-1:0] UA_IN_DIR    = 9'h088;
   localparam logic [UPC_W-1:0] UA_IN_IDX    = 9'h089;
   localparam logic [UPC_W-1:0] UA_OUT_DIR   = 9'h08a;
   localparam logic [UPC_W-1:0] UA_OUT_IDX   = 9'h08b;
   localparam logic [UPC_W-1:0] UA_IN_ACC    = 9'h006;
   localparam logic [UPC_W-1:0] UA_IN_STORE  = 9'h007;
   localparam logic [UPC_W-1:0] UA_OUT_XFER  = 9'h008;
   localparam logic [UPC_W-1:0] UA_INT_1     = 9'h0bf;
   localparam logic [UPC_W-1:0] UA_INT_2     = 9'h05f;
   localparam logic [UPC_W-1:0] UA_INT_3     = 9'h058;
   localparam logic [UPC_W-1:0] UA_INT_4     = 9'h059;
   localparam logic [UPC_W-1:0] UA_INT_5     = 9'h069;
   localparam logic [UPC_W-1:0] UA_INT_6     = 9'h06c;
   localparam logic [UPC_W-1:0] UA_INT_7     = 9'h06d;
   localparam logic [UPC_W-1:0] UA_INT_8     = 9'h06f;
   localparam logic [UPC_W-1:0] UA_INT_9     = 9'h0af;
   localparam logic [UPC_W-1:0] UA_CALL_PUSH = 9'h0ad;

   // Conditional jumps stay in a block of eight rows (row = upc[8:4])
   localparam int BLOCK_LSB = 7;

   // Interrupt structure is port zero; level kept to its low byte
   localparam logic [DATA_W-1:0] PORT_INTERRUPT = 16'h0000;
   localparam logic [DATA_W-1:0] LEVEL_MASK     = 16'h00ff;

   // Reset values
   localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;

   // Bus-control codes
   typedef enum logic [1:0] {
      BUS_IDLE       = 2'b00,
      request_input  = 2'b01,
      request_output = 2'b10
   } bus_ctl_t;

   // Decoded operation
   typedef enum logic [2:0] {
      OP_NONE               = 3'd0,
      input_direct_op       = 3'd1,
      output_direct_op      = 3'd2,
      input_indexed_op      = 3'd3,
      output_indexed_op     = 3'd4
   } io_op_t;

   // Next-address forms
   typedef enum logic [1:0] {
      NA_TABLE  = 2'd0,
      NA_ROWZ   = 2'd1,
      NA_FORCE  = 2'd2,
      NA_LIMIT  = 2'd3
   } next_kind_t;
endpackage : io_seq_pkg

// ==== rtl/io_op_decode.sv ====
// Major-opcode decoder for the I/O macro-instruction group
`timescale 1ns/1ps
module io_op_decode
   import io_seq_pkg::*;
(
   // Instruction fields
   input  wire logic [3:0] i_major,
   input  wire logic [3:0] i_minor,
   // Result
   output io_op_t          o_op
);
   // Minor field deliberately unused: all sixteen codes behave the same
   logic unused_minor;
   assign unused_minor = ^i_minor;

   always_comb begin
      unique case (i_major)
         MAJ_INPUT_DIRECT:   o_op = input_direct_op;
         MAJ_OUTPUT_DIRECT:  o_op = output_direct_op;
         MAJ_INPUT_INDEXED:  o_op = input_indexed_op;
         MAJ_OUTPUT_INDEXED: o_op = output_indexed_op;
         default:            o_op = OP_NONE;
      endcase
   end
endmodule : io_op_decode

// ==== rtl/micro_next_addr.sv ====
// Next microprogram address former
`timescale 1ns/1ps
module micro_next_addr
   import io_seq_pkg::*;
(
   // Selection
   input  next_kind_t       i_kind,
   input  wire logic [UPC_W-1:0] i_cur,
   input  wire logic [UPC_W-1:0] i_target,
   // Result
   output logic [UPC_W-1:0] o_next
);
   always_comb begin
      unique case (i_kind)
         NA_TABLE: o_next = i_target;
         // Row-zero jump keeps only the column
         NA_ROWZ:  o_next = {{(UPC_W-COL_W){1'b0}}, i_target[COL_W-1:0]};
         // Interrupt overrides whatever the sequence wanted
         NA_FORCE: o_next = UA_INTERRUPT;
         // Limited jumps cannot leave the current eight-row block
         NA_LIMIT: o_next = {i_cur[UPC_W-1:BLOCK_LSB], i_target[BLOCK_LSB-1:0]};
      endcase
   end
endmodule : micro_next_addr

// ==== rtl/io_interrupt_microsequence.sv ====
// Microsequencer for I/O macro-instructions and interrupt entry
`timescale 1ns/1ps
module io_interrupt_microsequence
   import io_seq_pkg::*;
(
   // Clock and reset
   input  wire logic              i_sys_clk,
   input  wire logic              i_nrst,
   // Macro-instruction at fetch
   input  wire logic              i_instr_valid,
   input  wire logic [3:0]        i_major,
   input  wire logic [3:0]        i_minor,
   input  wire logic [DATA_W-1:0] i_disp,
   input  wire logic [DATA_W-1:0] i_x,
   // Interrupt request and call-push completion
   input  wire logic              i_int_req,
   input  wire logic              i_call_push_done,
   // Port and memory read data
   input  wire logic [DATA_W-1:0] i_io_rdata,
   input  wire logic [DATA_W-1:0] i_mem_rdata,
   // Microprogram address and status
   output logic [UPC_W-1:0]       o_upc,
   output logic                   o_fetch,
   output logic                   o_foreign_op,
   output logic                   o_int_ack,
   output logic                   o_call_push,
   // Address register and bus control
   output logic [DATA_W-1:0]      o_mar,
   output bus_ctl_t               o_bus_ctl,
   output logic [DATA_W-1:0]      o_io_wdata,
   output logic                   o_mem_rd,
   output logic                   o_mem_wr,
   output logic [DATA_W-1:0]      o_mem_wdata,
   // Architectural registers
   output logic [DATA_W-1:0]      o_reg_a,
   output logic [DATA_W-1:0]      o_reg_s,
   output logic [DATA_W-1:0]      o_reg_w,
   output logic [DATA_W-1:0]      o_scratch_reg,
   output logic                   o_carry,
   // Reset value of the stack pointer
   input  wire logic [DATA_W-1:0] i_stack_init
);
   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [4:0] {
      ST_INIT     = 5'b00000,
      ST_FETCH    = 5'b00001,
      ST_IN_DIR   = 5'b00011,
      ST_IN_IDX   = 5'b00010,
      ST_IN_ACC   = 5'b00110,
      ST_IN_STORE = 5'b00111,
      ST_OUT_DIR  = 5'b00101,
      ST_OUT_IDX  = 5'b00100,
      ST_OUT_XFER = 5'b01100,
      ST_INT_0    = 5'b01101,
      ST_INT_1    = 5'b01111,
      ST_INT_2    = 5'b01110,
      ST_INT_3    = 5'b01010,
      ST_INT_4    = 5'b01011,
      ST_INT_5    = 5'b01001,
      ST_INT_6    = 5'b01000,
      ST_INT_7    = 5'b11000,
      ST_INT_8    = 5'b11001,
      ST_INT_9    = 5'b11011,
      ST_CALL     = 5'b11010
   } state_t;

   state_t            state_q, state_d;
   io_op_t            op;
   next_kind_t        kind;
   logic [UPC_W-1:0]  target, upc_d, upc_q;
   logic [DATA_W-1:0] ac_q, ac_d, a_q, a_d, s_q, s_d, w_q, w_d, scr_q, scr_d;
   logic [DATA_W-1:0] mar_q, mar_d, iow_q, iow_d, memw_q, memw_d;
   bus_ctl_t          bus_q, bus_d;
   logic              rd_q, rd_d, wr_q, wr_d, cy_q, cy_d, stack_ld_q;
   logic              fetch_q, fetch_d, foreign_q, foreign_d;
   logic              ack_q, ack_d, cp_q, cp_d;

   io_op_decode u_decode (
      .i_major (i_major),
      .i_minor (i_minor),
      .o_op    (op)
   );

   micro_next_addr u_next (
      .i_kind   (kind),
      .i_cur    (upc_q),
      .i_target (target),
      .o_next   (upc_d)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequence control
   always_comb begin
      state_d   = state_q;
      foreign_d = 1'b0;
      ack_d     = 1'b0;
      unique case (state_q)
         ST_INIT:     state_d = ST_FETCH;
         ST_FETCH: begin
            if (i_int_req) begin
               state_d = ST_INT_0;
               ack_d   = 1'b1;
            end else if (i_instr_valid) begin
               unique case (op)
                  input_direct_op:   state_d = ST_IN_DIR;
                  input_indexed_op:  state_d = ST_IN_IDX;
                  output_direct_op:  state_d = ST_OUT_DIR;
                  output_indexed_op: state_d = ST_OUT_IDX;
                  OP_NONE:           foreign_d = 1'b1;
               endcase
            end
         end
         ST_IN_DIR,
         ST_IN_IDX:   state_d = ST_IN_ACC;
         ST_IN_ACC:   state_d = ST_IN_STORE;
         ST_IN_STORE: state_d = ST_FETCH;
         ST_OUT_DIR,
         ST_OUT_IDX:  state_d = ST_OUT_XFER;
         ST_OUT_XFER: state_d = ST_FETCH;
         ST_INT_0:    state_d = ST_INT_1;
         ST_INT_1:    state_d = ST_INT_2;
         ST_INT_2:    state_d = ST_INT_3;
         ST_INT_3:    state_d = ST_INT_4;
         ST_INT_4:    state_d = ST_INT_5;
         ST_INT_5:    state_d = ST_INT_6;
         ST_INT_6:    state_d = ST_INT_7;
         ST_INT_7:    state_d = ST_INT_8;
         ST_INT_8:    state_d = ST_INT_9;
         ST_INT_9:    state_d = ST_CALL;
         ST_CALL:     if (i_call_push_done) state_d = ST_FETCH;
         default:     state_d = ST_INIT;
      endcase
   end

   // Microprogram address of the next state
   always_comb begin
      kind   = NA_TABLE;
      target = UA_FETCH;
      unique case (state_d)
         ST_INIT:     target = UA_INIT;
         ST_FETCH: begin
            target = UA_FETCH;
            if (state_q == ST_IN_STORE || state_q == ST_OUT_XFER) kind = NA_ROWZ;
         end
         ST_IN_DIR:   target = UA_IN_DIR;
         ST_IN_IDX:   target = UA_IN_IDX;
         ST_IN_ACC:   target = UA_IN_ACC;
         ST_IN_STORE: target = UA_IN_STORE;
         ST_OUT_DIR:  target = UA_OUT_DIR;
         ST_OUT_IDX:  target = UA_OUT_IDX;
         ST_OUT_XFER: target = UA_OUT_XFER;
         ST_INT_0:    kind   = NA_FORCE;
         ST_INT_1:    target = UA_INT_1;
         ST_INT_2:    target = UA_INT_2;
         ST_INT_3:    target = UA_INT_3;
         ST_INT_4:    target = UA_INT_4;
         ST_INT_5:    target = UA_INT_5;
         ST_INT_6:    target = UA_INT_6;
         ST_INT_7:    target = UA_INT_7;
         ST_INT_8:    target = UA_INT_8;
         ST_INT_9:    target = UA_INT_9;
         ST_CALL:     target = UA_CALL_PUSH;
         default:     target = UA_INIT;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Datapath and bus requests; datapath updates decoded from the current state, requests and strobes registered from the next state
   always_comb begin
      ac_d    = ac_q;
      a_d     = a_q;
      s_d     = s_q;
      w_d     = w_q;
      scr_d   = scr_q;
      cy_d    = cy_q;
      mar_d   = mar_q;
      iow_d   = iow_q;
      memw_d  = memw_q;
      bus_d   = BUS_IDLE;
      rd_d    = 1'b0;
      wr_d    = 1'b0;
      fetch_d = (state_d == ST_FETCH);
      cp_d    = (state_d == ST_CALL);
      // Effects taken on leaving the current state
      unique case (state_q)
         ST_IN_DIR,
         ST_IN_IDX:   ac_d = i_io_rdata;
         ST_IN_STORE: a_d  = ac_q;
         ST_INT_0:    s_d  = s_q - 16'h0001;
         ST_INT_4:    ac_d = i_io_rdata & LEVEL_MASK;
         ST_INT_6: begin
            w_d  = ac_q;
            cy_d = 1'b1;
         end
         ST_INT_8:    ac_d = i_mem_rdata;
         ST_INT_9:    scr_d = ac_q;
         default: ;
      endcase
      // Requests presented while in the next state
      unique case (state_d)
         ST_IN_DIR: begin
            mar_d = i_disp;
            bus_d = request_input;
         end
         ST_IN_IDX: begin
            mar_d = i_x;
            bus_d = request_input;
         end
         ST_OUT_DIR:  mar_d = i_disp;
         ST_OUT_IDX:  mar_d = i_x;
         ST_OUT_XFER: begin
            iow_d = a_q;
            bus_d = request_output;
         end
         ST_INT_2: begin
            mar_d  = s_q;
            memw_d = w_q;
            wr_d   = 1'b1;
         end
         ST_INT_3:    mar_d = PORT_INTERRUPT;
         ST_INT_4:    bus_d = request_input;
         ST_INT_5: begin
            iow_d = i_io_rdata & LEVEL_MASK;
            bus_d = request_output;
         end
         ST_INT_7: begin
            mar_d = ac_q;
            rd_d  = 1'b1;
         end
         default: ;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         state_q    <= ST_INIT;
         upc_q      <= UA_INIT;
         ac_q       <= RST_WORD;
         a_q        <= RST_WORD;
         s_q        <= RST_WORD;
         w_q        <= RST_WORD;
         scr_q      <= RST_WORD;
         cy_q       <= 1'b0;
         mar_q      <= RST_WORD;
         iow_q      <= RST_WORD;
         memw_q     <= RST_WORD;
         bus_q      <= BUS_IDLE;
         rd_q       <= 1'b0;
         wr_q       <= 1'b0;
         fetch_q    <= 1'b0;
         foreign_q  <= 1'b0;
         ack_q      <= 1'b0;
         cp_q       <= 1'b0;
         stack_ld_q <= 1'b1;
      end else begin
         state_q    <= state_d;
         upc_q      <= upc_d;
         ac_q       <= ac_d;
         a_q        <= a_d;
         // Stack pointer strap caught on the first edge after release
         s_q        <= stack_ld_q ? i_stack_init : s_d;
         stack_ld_q <= 1'b0;
         w_q        <= w_d;
         scr_q      <= scr_d;
         cy_q       <= cy_d;
         mar_q      <= mar_d;
         iow_q      <= iow_d;
         memw_q     <= memw_d;
         bus_q      <= bus_d;
         rd_q       <= rd_d;
         wr_q       <= wr_d;
         fetch_q    <= fetch_d;
         foreign_q  <= foreign_d;
         ack_q      <= ack_d;
         cp_q       <= cp_d;
      end
   end

   assign o_upc         = upc_q;
   assign o_fetch       = fetch_q;
   assign o_foreign_op  = foreign_q;
   assign o_int_ack     = ack_q;
   assign o_call_push   = cp_q;
   assign o_mar         = mar_q;
   assign o_bus_ctl     = bus_q;
   assign o_io_wdata    = iow_q;
   assign o_mem_rd      = rd_q;
   assign o_mem_wr      = wr_q;
   assign o_mem_wdata   = memw_q;
   assign o_reg_a       = a_q;
   assign o_reg_s       = s_q;
   assign o_reg_w       = w_q;
   assign o_scratch_reg = scr_q;
   assign o_carry       = cy_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_int_entry;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (state_q == ST_FETCH && i_int_req) |=> (o_upc == UA_INTERRUPT && o_int_ack);
   endproperty
   a_int_entry: assert property (p_int_entry) else $error("interrupt entry not forced");

   property p_minor_ignored;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (state_q == ST_FETCH && !i_int_req && i_instr_valid && i_major == MAJ_INPUT_DIRECT)
         |=> (o_bus_ctl == request_input && o_mar == $past(i_disp));
   endproperty
   a_minor_ignored: assert property (p_minor_ignored) else $error("direct input not started");

   property p_out_xfer;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (state_q == ST_FETCH && !i_int_req && i_instr_valid && i_major == MAJ_OUTPUT_INDEXED)
         |=> ##1 (o_bus_ctl == request_output && o_io_wdata == o_reg_a && o_mar == $past(i_x, 2));
   endproperty
   a_out_xfer: assert property (p_out_xfer) else $error("indexed output wrong");

   property p_in_load_a;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (o_bus_ctl == request_input && state_q == ST_IN_IDX)
         |=> ##2 (o_reg_a == $past(i_io_rdata, 3) && o_upc == UA_FETCH);
   endproperty
   a_in_load_a: assert property (p_in_load_a) else $error("input word not loaded to A");

   property p_push_status;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (state_q == ST_FETCH && i_int_req)
         |=> ##2 (o_mem_wr && o_mar == $past(o_reg_s, 2) - 16'h0001 && o_mem_wdata == o_reg_w);
   endproperty
   a_push_status: assert property (p_push_status) else $error("status not pushed");

   property p_level_back;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (o_bus_ctl == request_input && state_q == ST_INT_4)
         |-> (o_mar == PORT_INTERRUPT) ##1
             (o_bus_ctl == request_output && o_mar == PORT_INTERRUPT
              && o_io_wdata == ($past(i_io_rdata) & LEVEL_MASK));
   endproperty
   a_level_back: assert property (p_level_back) else $error("level not written back");

   property p_status_carry;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (state_q == ST_INT_5) |=> ##1 (o_carry && o_reg_w == o_io_wdata);
   endproperty
   a_status_carry: assert property (p_status_carry) else $error("status or carry wrong");

   property p_handler;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (state_q == ST_INT_7) |=> ##2 (o_scratch_reg == $past(i_mem_rdata, 2)
                                     && o_upc == UA_CALL_PUSH && o_call_push);
   endproperty
   a_handler: assert property (p_handler) else $error("handler address not kept");

   property p_init;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (state_q == ST_INIT) |-> (o_upc == UA_INIT) ##1 (o_upc == UA_FETCH);
   endproperty
   a_init: assert property (p_init) else $error("entry points misplaced");

   property p_limited;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (kind == NA_LIMIT) |-> (upc_d[UPC_W-1:BLOCK_LSB] == upc_q[UPC_W-1:BLOCK_LSB]);
   endproperty
   a_limited: assert property (p_limited) else $error("limited jump left its block");

   c_int:   cover property (@(posedge i_sys_clk) disable iff (!i_nrst) state_q == ST_CALL);
   c_input: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) state_q == ST_IN_STORE);
   c_out:   cover property (@(posedge i_sys_clk) disable iff (!i_nrst) state_q == ST_OUT_XFER);
   c_other: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) o_foreign_op);
endmodule : io_interrupt_microsequence

// ==== bench/io_port_model.sv ====
// Far-side model: I/O ports, interrupt structure at port zero, memory
`timescale 1ns/1ps
module io_port_model
   import io_seq_pkg::*;
(
   // Clock
   input  wire logic              i_sys_clk,
   // From the sequencer
   input  bus_ctl_t               i_bus_ctl,
   input  wire logic [DATA_W-1:0] i_mar,
   input  wire logic [DATA_W-1:0] i_io_wdata,
   input  wire logic              i_mem_rd,
   // Pending interrupt level
   input  wire logic [DATA_W-1:0] i_level,
   // To the sequencer and the bench
   output logic [DATA_W-1:0]      o_io_rdata,
   output logic [DATA_W-1:0]      o_mem_rdata,
   output logic [DATA_W-1:0]      o_port_latch,
   output logic [DATA_W-1:0]      o_mask_level
);
   logic [DATA_W-1:0] junk_q = 16'h1234;
   logic [DATA_W-1:0] maddr_q = 16'h0000;
   logic              mrd_q = 1'b0;
   logic [DATA_W-1:0] latch_q = 16'h0000;
   logic [DATA_W-1:0] mask_q = 16'h0000;
   ////////////////////////////////////////////////////////////////////////////
   // Undriven bus shows a word that changes each cycle, never a stale value
   always_comb begin
      if (i_bus_ctl == request_input) begin
         o_io_rdata = (i_mar == PORT_INTERRUPT) ? i_level : (i_mar ^ 16'h5a3c);
      end else begin
         o_io_rdata = junk_q;
      end
      o_mem_rdata = mrd_q ? (maddr_q ^ 16'hc3a5) : ~junk_q;
   end
   assign o_port_latch = latch_q;
   assign o_mask_level = mask_q;
   always @(posedge i_sys_clk) begin
      junk_q <= {junk_q[14:0], ~junk_q[15]};
      mrd_q <= i_mem_rd;
      maddr_q <= i_mar;
      if (i_bus_ctl == request_output) begin
         latch_q <= i_io_wdata;
         if (i_mar == PORT_INTERRUPT) begin
            mask_q <= i_io_wdata;
         end
      end
   end
endmodule : io_port_model

// ==== bench/io_interrupt_microsequence_bench.sv ====
// Self-checking bench for the I/O and interrupt-entry microsequencer
`timescale 1ns/1ps
module io_interrupt_microsequence_bench;
   import io_seq_pkg::*;
   logic i_sys_clk, i_nrst, i_instr_valid, i_int_req, i_call_push_done;
   logic [3:0] i_major, i_minor;
   logic [DATA_W-1:0] i_disp, i_x, i_io_rdata, i_mem_rdata, i_stack_init, level, latch, mask;
   logic [UPC_W-1:0] o_upc;
   logic o_fetch, o_foreign_op, o_int_ack, o_call_push, o_mem_rd, o_mem_wr, o_carry;
   logic [DATA_W-1:0] o_mar, o_io_wdata, o_mem_wdata, o_reg_a, o_reg_s, o_reg_w, o_scratch_reg;
   logic [DATA_W-1:0] exp_s, exp_w, exp_a;
   bus_ctl_t o_bus_ctl;
   int bad_count = 0;
   int cmp_count = 0;
   int seed = 32'h8fe8;
   io_interrupt_microsequence dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_instr_valid(i_instr_valid),
      .i_major(i_major), .i_minor(i_minor), .i_disp(i_disp), .i_x(i_x), .i_int_req(i_int_req),
      .i_call_push_done(i_call_push_done), .i_io_rdata(i_io_rdata), .i_mem_rdata(i_mem_rdata),
      .o_upc(o_upc), .o_fetch(o_fetch), .o_foreign_op(o_foreign_op), .o_int_ack(o_int_ack),
      .o_call_push(o_call_push), .o_mar(o_mar), .o_bus_ctl(o_bus_ctl), .o_io_wdata(o_io_wdata),
      .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .o_reg_a(o_reg_a),
      .o_reg_s(o_reg_s), .o_reg_w(o_reg_w), .o_scratch_reg(o_scratch_reg), .o_carry(o_carry),
      .i_stack_init(i_stack_init));
   io_port_model far (.i_sys_clk(i_sys_clk), .i_bus_ctl(o_bus_ctl), .i_mar(o_mar), .i_io_wdata(o_io_wdata),
      .i_mem_rd(o_mem_rd), .i_level(level), .o_io_rdata(i_io_rdata), .o_mem_rdata(i_mem_rdata),
      .o_port_latch(latch), .o_mask_level(mask));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results
   // Inputs change and outputs are read 1 ns after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask : tick
   task automatic wait_fetch;
      for (int k = 0; k < 50 && o_fetch !== 1'b1; k++) tick(1);
      if (o_fetch !== 1'b1) begin
         bad_count++;
         results;
      end
   endtask : wait_fetch
   ////////////////////////////////////////////////////////////////////////////
   task automatic io_op(input logic [3:0] maj);
      logic [15:0] port;
      logic [UPC_W-1:0] ent;
      wait_fetch;
      i_major = maj;
      i_minor = 4'($random(seed));
      i_disp = 16'($random(seed)) | 16'h0001;
      i_x = 16'($random(seed)) | 16'h0001;
      i_instr_valid = 1'b1;
      port = maj[1] ? i_x : i_disp;
      ent = maj[0] ? (maj[1] ? UA_OUT_IDX : UA_OUT_DIR) : (maj[1] ? UA_IN_IDX : UA_IN_DIR);
      tick(1);
      i_instr_valid = 1'b0;
      check("upc", {7'h0, o_upc}, {7'h0, ent});
      check("mar", o_mar, port);
      if (!maj[0]) begin
         check("bus", {14'h0, o_bus_ctl}, {14'h0, request_input});
         exp_a = port ^ 16'h5a3c;
         tick(3);
         check("reg_a", o_reg_a, exp_a);
      end else begin
         tick(1);
         check("bus", {14'h0, o_bus_ctl}, {14'h0, request_output});
         check("io_wdata", o_io_wdata, exp_a);
         check("mar", o_mar, port);
         tick(1);
         check("latch", latch, exp_a);
      end
      check("upc", {7'h0, o_upc}, {7'h0, UA_FETCH});
   endtask : io_op
   task automatic intr;
      wait_fetch;
      level = 16'($random(seed)) | 16'h0100;
      i_int_req = 1'b1;
      tick(1);
      i_int_req = 1'b0;
      check("upc", {7'h0, o_upc}, {7'h0, UA_INTERRUPT});
      check("ack", {15'h0, o_int_ack}, 16'h0001);
      tick(2);
      exp_s = exp_s - 16'h0001;
      check("reg_s", o_reg_s, exp_s);
      check("mar", o_mar, exp_s);
      check("mem_wdata", o_mem_wdata, exp_w);
      check("mem_wr", {15'h0, o_mem_wr}, 16'h0001);
      tick(2);
      check("bus", {14'h0, o_bus_ctl}, {14'h0, request_input});
      check("mar", o_mar, PORT_INTERRUPT);
      tick(1);
      exp_w = level & 16'h00ff;
      check("bus", {14'h0, o_bus_ctl}, {14'h0, request_output});
      check("io_wdata", o_io_wdata, exp_w);
      tick(2);
      check("reg_w", o_reg_w, exp_w);
      check("carry", {15'h0, o_carry}, 16'h0001);
      check("mar", o_mar, exp_w);
      check("mem_rd", {15'h0, o_mem_rd}, 16'h0001);
      tick(3);
      check("upc", {7'h0, o_upc}, {7'h0, UA_CALL_PUSH});
      check("scratch", o_scratch_reg, exp_w ^ 16'hc3a5);
      check("call_push", {15'h0, o_call_push}, 16'h0001);
      check("mask", mask, exp_w);
      i_call_push_done = 1'b1;
      tick(1);
      wait_fetch;
      i_call_push_done = 1'b0;
   endtask : intr
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      i_sys_clk = 1'b0;
      forever #10 i_sys_clk = ~i_sys_clk;
   end
   initial begin
      i_nrst = 1'b0;
      {i_instr_valid, i_int_req, i_call_push_done} = 3'h0;
      {i_major, i_minor, i_disp, i_x, level} = '0;
      i_stack_init = 16'($random(seed)) | 16'h0100;
      exp_s = i_stack_init;
      exp_w = RST_WORD;
      exp_a = RST_WORD;
      tick(3);
      check("upc", {7'h0, o_upc}, {7'h0, UA_INIT});
      i_nrst = 1'b1;
      tick(2);
      check("upc", {7'h0, o_upc}, {7'h0, UA_FETCH});
      for (int k = 0; k < 8; k++) io_op(MAJ_INPUT_DIRECT + 4'(k % 4));
      wait_fetch;
      i_major = 4'h3;
      i_instr_valid = 1'b1;
      tick(1);
      i_instr_valid = 1'b0;
      check("foreign", {15'h0, o_foreign_op}, 16'h0001);
      check("upc", {7'h0, o_upc}, {7'h0, UA_FETCH});
      intr;
      intr;
      io_op(MAJ_OUTPUT_INDEXED);
      results;
   end
endmodule : io_interrupt_microsequence_bench
